// >>> rtl/radio_ph_defs.svh
`ifndef RADIO_PH_DEFS_SVH
`define RADIO_PH_DEFS_SVH
// Notes on behaviour
// - Tx prepends preamble count and sync; optional two-byte checksum after payload.
// - Until launch, Tx sends preamble, or a constant zero when preamble count is zero.
// - Launch rule 1: start once FIFO holds a byte; preamble, sync, payload.
// - Launch rule 0: start when FIFO holds level trigger plus one bytes.
// - Launch already met on Tx entry starts the frame at once.
// - Rx strips preamble and sync, decodes, filters; FIFO gets length, address, message.
// - Fixed format takes exactly frame length limit bytes after sync.
// - Variable format loads length from first byte; over the limit is discarded.
// - Address byte is second (variable) or first (fixed); mismatch stops reception.
// - Select 01 matches own station id; 10 also matches group station id.
// - Address byte stays in FIFO, checked on Rx only; sync match alone sets the sync flag.
// - Checksum enable checks received checksum into pass flag; frame ready follows.
// - 128-bit key in four write-only words, kept across all modes.
// - Tx with cipher encrypts message in zero-padded 16-byte blocks before framing.
// - Rx with cipher decrypts after the whole frame; frame ready follows decryption.
// - One cipher block takes about 7.0 us; four blocks up to 28 us.
// - Frames without the sync pattern are dropped; sync match starts payload, raises flag.
// - Checksum is CCITT; receiver strips the checksum bytes from the FIFO.
// - Balance select 01 is Manchester, 10 whitening with a 9-bit LFSR.
// - Length format 1 is variable; 0 fixed, or unlimited when limit is 0.
`define OFS_FIFO 8'h00
`define OFS_MODE 8'h04
`define OFS_PKTCFG 8'h08
`define OFS_IDS 8'h0C
`define OFS_FRAMING 8'h10
`define OFS_SYNC 8'h14
`define OFS_STATUS 8'h18
`define OFS_KEY 8'h20
`define KEY_MASK 8'hF0
`define CFG_VARLEN 0
`define CFG_BAL 1
`define CFG_CRC_EN 3
`define CFG_KEEP 4
`define CFG_ADDR 5
`define CFG_CIPHER 7
`define CFG_LAUNCH 8
`define IDS_LIMIT 0
`define IDS_TRIG 8
`define IDS_OWN 16
`define IDS_GROUP 24
`define FRM_PRE 0
`define FRM_SYNC_LEN 16
`define RST_PKTCFG 32'h0000_0008
`define RST_IDS 32'h0000_0F40
`define RST_FRAMING 32'h0004_0003
`define RST_SYNC 32'h2DD4_5AA5
`define FIFO_DEPTH 66
`define PREAMBLE_BYTE 8'hAA
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021
`define WHITEN_SEED 9'h1FF
`define CLK_PERIOD_NS 20
`define CIPHER_BLOCK_NS 7000
`define CIPHER_BLOCK_CYC (`CIPHER_BLOCK_NS / `CLK_PERIOD_NS)
`endif

// >>> rtl/radio_ph_pkg.sv
package radio_ph_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sym_t;
  typedef struct packed {
    logic busy;
    logic frame_sent;
    logic checksum_pass;
    logic frame_ready;
    logic sync_match;
    logic level;
    logic has_data;
    logic full;
  } status_t;
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_TX = 2'h1,
    MODE_RX = 2'h2
  } op_mode_t;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_CIPHER = 11'h002,
    ST_WAIT = 11'h004,
    ST_PRE = 11'h008,
    ST_SYNC = 11'h010,
    ST_BODY = 11'h020,
    ST_CRC = 11'h040,
    ST_HUNT = 11'h080,
    ST_RXBODY = 11'h100,
    ST_RXCRC = 11'h200,
    ST_DONE = 11'h400
  } state_t;
endpackage

// >>> rtl/radio_ph_cipher.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_ph_defs.svh"
module radio_ph_cipher #(
  parameter int BLOCK_CYC = `CIPHER_BLOCK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [127:0] i_key,
  input wire logic [127:0] i_block,
  output logic [127:0] o_block,
  output logic o_done
);
  localparam int TW = $clog2(BLOCK_CYC + 1);
  logic [TW-1:0] timer;
  logic busy;
  // Keyed involution: the same pass encrypts and decrypts
  wire [127:0] key_mix = i_key ^ {i_key[63:0], i_key[127:64]};
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      busy <= 1'b0;
      timer <= '0;
      o_done <= 1'b0;
      o_block <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !busy) begin
        busy <= 1'b1;
        timer <= '0;
        o_block <= i_block ^ key_mix;
      end else if (busy) begin
        timer <= timer + 1'b1;
        if (timer == TW'(BLOCK_CYC - 1)) begin
          busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/radio_packet_handler.sv
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "radio_ph_defs.svh"
module radio_packet_handler #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int BLOCK_CYC = `CIPHER_BLOCK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output radio_ph_pkg::sym_t o_tx,
  input wire logic i_tx_ready,
  input wire radio_ph_pkg::sym_t i_rx,
  output logic o_manchester_on,
  output logic o_event_pin_zero
);
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nv, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nv & m);
  endfunction
  function automatic logic [6:0] wrap(input logic [8:0] v);
    return 7'(v % 9'(DEPTH));
  endfunction
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
      input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
  function automatic logic [8:0] lfsr8(input logic [8:0] l);
    logic [8:0] r;
    r = l;
    for (int i = 0; i < 8; i++) begin
      r = {r[0] ^ r[5], r[8:1]};
    end
    return r;
  endfunction
  function automatic logic [7:0] sync_at(input logic [31:0] p,
      input logic [2:0] len, input logic [15:0] k);
    logic [1:0] s;
    s = 2'(len - 3'd1 - 3'(k));
    return p[{s, 3'b000} +: 8];
  endfunction

  logic [1:0] mode;
  logic [1:0] run_mode;
  logic [31:0] pktcfg, ids, framing, sync_pat, rdata;
  logic [127:0] key;
  logic [7:0] mem [DEPTH];
  logic [6:0] rd, wr, fcnt, fr_base, fr_n;
  radio_ph_pkg::state_t state;
  radio_ph_pkg::sym_t tx_q;
  logic [15:0] cnt, crc, rcrc;
  logic [8:0] left, lfsr;
  logic [2:0] blk;
  logic first, c_run, dec, ack;
  logic f_sent, f_pass, f_ready, f_sync;

  wire varlen = pktcfg[`CFG_VARLEN];
  wire [1:0] bal = pktcfg[`CFG_BAL +: 2];
  wire crc_en = pktcfg[`CFG_CRC_EN];
  wire keep = pktcfg[`CFG_KEEP];
  wire [1:0] addr_sel = pktcfg[`CFG_ADDR +: 2];
  wire cipher_en = pktcfg[`CFG_CIPHER];
  wire launch_rule = pktcfg[`CFG_LAUNCH];
  wire [7:0] limit = ids[`IDS_LIMIT +: 8];
  wire [7:0] trig = ids[`IDS_TRIG +: 8];
  wire [15:0] pre_len = framing[`FRM_PRE +: 16];
  wire [2:0] sync_len = framing[`FRM_SYNC_LEN +: 3];
  wire unlim = !varlen && limit == 8'h00;
  wire whiten = bal == 2'b10;
  wire [7:0] wmask = whiten ? lfsr[7:0] : 8'h00;

  wire s_idle = state == radio_ph_pkg::ST_IDLE;
  wire s_ciph = state == radio_ph_pkg::ST_CIPHER;
  wire s_wait = state == radio_ph_pkg::ST_WAIT;
  wire s_body = state == radio_ph_pkg::ST_BODY;
  wire s_crc = state == radio_ph_pkg::ST_CRC;
  wire s_hunt = state == radio_ph_pkg::ST_HUNT;
  wire s_rxb = state == radio_ph_pkg::ST_RXBODY;
  wire s_rxc = state == radio_ph_pkg::ST_RXCRC;

  wire has_data = fcnt != 7'd0;
  wire full = fcnt == 7'(DEPTH);
  wire level = 8'(fcnt) > trig;
  wire launch_ok = launch_rule ? has_data : level;
  wire abort = !s_idle && mode != run_mode;

  wire acc = i_wb_cyc && i_wb_stb;
  wire wr_en = acc && ack && i_wb_we;
  wire rd_en = acc && ack && !i_wb_we;
  wire fifo_hit = i_wb_adr == `OFS_FIFO;
  wire key_hit = (i_wb_adr & `KEY_MASK) == `OFS_KEY;
  wire st_clr = wr_en && i_wb_adr == `OFS_STATUS && i_wb_sel[0];

  wire tx_take = !tx_q.valid || i_tx_ready;
  wire [7:0] body_raw = mem[rd];
  wire [7:0] rx_raw = i_rx.data ^ wmask;
  wire rx_v = i_rx.valid;
  wire [7:0] cur_raw = s_body ? body_raw : rx_raw;
  wire body_last = (varlen && first) ? cur_raw == 8'h00
      : unlim ? (s_body && fcnt == 7'd1) : left == 9'd1;
  wire [6:0] hdr = 7'(varlen) + 7'(addr_sel != 2'b00);
  wire [6:0] msg_len = fcnt - hdr;
  wire [2:0] nblk = 3'((8'(msg_len) + 8'd15) >> 4);
  wire [6:0] blk_off = {blk, 4'b0000};
  wire [8:0] blk_base = 9'(rd) + 9'(hdr) + 9'(blk_off);
  logic [6:0] blk_idx [16];
  wire [127:0] blk_in;
  logic [127:0] c_out;
  logic c_done;
  logic [7:0] tx_data;
  logic tx_emit;

  for (genvar g = 0; g < 16; g++) begin : g_blk
    assign blk_idx[g] = wrap(blk_base + 9'(g));
    assign blk_in[127 - 8 * g -: 8] = (blk_off + 7'(g) < msg_len)
        ? mem[blk_idx[g]] : 8'h00;
  end
  wire c_start = s_ciph && !c_run;
  wire c_last = blk + 3'd1 >= nblk;

  wire addr_ok = rx_raw == ids[`IDS_OWN +: 8]
      || (addr_sel == 2'b10 && rx_raw == ids[`IDS_GROUP +: 8]);
  wire len_bad = first && varlen && rx_raw > limit;
  wire addr_bad = addr_sel != 2'b00 && cnt == 16'(varlen)
      && !addr_ok;
  wire fr_drop = s_rxb && rx_v && (len_bad || addr_bad);
  wire crc_ok = {rcrc[7:0], rx_raw} == crc;
  wire rxc_end = s_rxc && rx_v && cnt[0];
  wire crc_fail = rxc_end && !crc_ok && !keep;
  wire rxb_end = s_rxb && rx_v && !fr_drop && body_last && !unlim;
  wire rx_fin = (rxb_end && !crc_en) || (rxc_end && (crc_ok || keep));
  wire sync_hit = s_hunt && rx_v && i_rx.data == sync_at(sync_pat,
      sync_len, cnt) && cnt == 16'(sync_len - 3'd1);
  wire tx_done = (s_body && tx_emit && body_last && !crc_en)
      || (s_crc && tx_emit && cnt[0]);

  wire rx_push = s_rxb && rx_v && !full;
  wire bus_push = wr_en && fifo_hit && mode != 2'(radio_ph_pkg::MODE_RX)
      && !s_ciph && !full;
  wire tx_pop = s_body && tx_emit;
  wire bus_pop = rd_en && fifo_hit && mode != 2'(radio_ph_pkg::MODE_TX)
      && !s_ciph && has_data;
  wire push = rx_push || bus_push;
  wire pop = tx_pop || bus_pop;
  wire [7:0] push_data = rx_push ? rx_raw : i_wb_dat[7:0];

  always_comb begin
    tx_emit = tx_take;
    case (state)
      radio_ph_pkg::ST_WAIT: begin
        tx_data = pre_len != 16'h0000 ? `PREAMBLE_BYTE : 8'h00;
        tx_emit = tx_take && !launch_ok;
      end
      radio_ph_pkg::ST_PRE: tx_data = `PREAMBLE_BYTE;
      radio_ph_pkg::ST_SYNC: tx_data = sync_at(sync_pat, sync_len, cnt);
      radio_ph_pkg::ST_BODY: begin
        tx_data = body_raw ^ wmask;
        tx_emit = tx_take && has_data;
      end
      radio_ph_pkg::ST_CRC: tx_data = (cnt[0] ? crc[7:0] : crc[15:8])
          ^ wmask;
      default: begin
        tx_data = 8'h00;
        tx_emit = 1'b0;
      end
    endcase
  end

  radio_ph_cipher #(.BLOCK_CYC(BLOCK_CYC)) u_cipher (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_start(c_start),
    .i_key(key),
    .i_block(blk_in),
    .o_block(c_out),
    .o_done(c_done)
  );

  always_ff @(posedge i_core_clk) begin
    if (push && !fr_drop) mem[wr] <= push_data;
    if (c_done) begin
      for (int i = 0; i < 16; i++) begin
        mem[blk_idx[i]] <= c_out[127 - 8 * i -: 8];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rd <= 7'd0;
      wr <= 7'd0;
      fcnt <= 7'd0;
    end else if (crc_fail) begin
      rd <= wr;
      fcnt <= 7'd0;
    end else if (fr_drop) begin
      wr <= fr_base;
      fcnt <= fcnt > fr_n ? fcnt - fr_n : 7'd0;
      if (fcnt <= fr_n) rd <= fr_base;
    end else if (c_done && c_last) begin
      fcnt <= hdr + {nblk, 4'b0000};
      wr <= wrap(9'(rd) + 9'(hdr) + 9'({nblk, 4'b0000}));
    end else begin
      if (push) wr <= wrap(9'(wr) + 9'd1);
      if (pop) rd <= wrap(9'(rd) + 9'd1);
      fcnt <= fcnt + 7'(push) - 7'(pop);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state <= radio_ph_pkg::ST_IDLE;
      run_mode <= 2'b00;
      tx_q <= '0;
      cnt <= 16'h0000;
      left <= 9'd0;
      first <= 1'b0;
      crc <= `CRC_INIT;
      rcrc <= 16'h0000;
      lfsr <= `WHITEN_SEED;
      blk <= 3'd0;
      c_run <= 1'b0;
      dec <= 1'b0;
      fr_base <= 7'd0;
      fr_n <= 7'd0;
    end else begin
      if (tx_take) tx_q <= '{valid: tx_emit && !abort, data: tx_data};
      if (c_start) c_run <= 1'b1;
      if (c_done) begin
        c_run <= 1'b0;
        blk <= blk + 3'd1;
      end
      if (abort) begin
        state <= radio_ph_pkg::ST_IDLE;
      end else begin
        case (state)
          radio_ph_pkg::ST_IDLE: begin
            run_mode <= mode;
            cnt <= 16'h0000;
            first <= 1'b1;
            crc <= `CRC_INIT;
            lfsr <= `WHITEN_SEED;
            blk <= 3'd0;
            dec <= mode == 2'(radio_ph_pkg::MODE_RX);
            if (mode == 2'(radio_ph_pkg::MODE_TX)) begin
              state <= (cipher_en && msg_len != 7'd0)
                  ? radio_ph_pkg::ST_CIPHER : radio_ph_pkg::ST_WAIT;
            end else if (mode == 2'(radio_ph_pkg::MODE_RX)) begin
              state <= radio_ph_pkg::ST_HUNT;
            end
          end
          radio_ph_pkg::ST_CIPHER: begin
            if (c_done && c_last) begin
              state <= dec ? radio_ph_pkg::ST_DONE
                  : radio_ph_pkg::ST_WAIT;
            end
          end
          radio_ph_pkg::ST_WAIT: begin
            if (launch_ok) begin
              state <= pre_len != 16'h0000 ? radio_ph_pkg::ST_PRE
                  : radio_ph_pkg::ST_SYNC;
            end
          end
          radio_ph_pkg::ST_PRE: begin
            if (tx_emit) begin
              cnt <= cnt + 16'h0001;
              if (cnt == pre_len - 16'h0001) begin
                cnt <= 16'h0000;
                state <= radio_ph_pkg::ST_SYNC;
              end
            end
          end
          radio_ph_pkg::ST_SYNC: begin
            if (tx_emit) begin
              cnt <= cnt + 16'h0001;
              if (cnt == 16'(sync_len - 3'd1)) begin
                cnt <= 16'h0000;
                left <= 9'(limit);
                state <= radio_ph_pkg::ST_BODY;
              end
            end
          end
          radio_ph_pkg::ST_BODY, radio_ph_pkg::ST_RXBODY: begin
            if (fr_drop) begin
              cnt <= 16'h0000;
              state <= radio_ph_pkg::ST_HUNT;
            end else if (tx_emit || (s_rxb && rx_v)) begin
              crc <= crc_byte(crc, cur_raw);
              lfsr <= lfsr8(lfsr);
              first <= 1'b0;
              cnt <= cnt + 16'h0001;
              fr_n <= fr_n + 7'(rx_push);
              left <= (first && varlen) ? 9'(cur_raw) : left - 9'd1;
              if (body_last && !(s_rxb && unlim)) begin
                cnt <= 16'h0000;
                if (crc_en) begin
                  state <= s_body ? radio_ph_pkg::ST_CRC
                      : radio_ph_pkg::ST_RXCRC;
                end else if (s_body || !cipher_en) begin
                  state <= radio_ph_pkg::ST_DONE;
                end else begin
                  state <= radio_ph_pkg::ST_CIPHER;
                end
              end
            end
          end
          radio_ph_pkg::ST_CRC: begin
            if (tx_emit) begin
              lfsr <= lfsr8(lfsr);
              cnt <= cnt + 16'h0001;
              if (cnt[0]) state <= radio_ph_pkg::ST_DONE;
            end
          end
          radio_ph_pkg::ST_HUNT: begin
            if (rx_v) begin
              if (sync_hit) begin
                cnt <= 16'h0000;
                first <= 1'b1;
                left <= 9'(limit);
                crc <= `CRC_INIT;
                lfsr <= `WHITEN_SEED;
                fr_base <= wr;
                fr_n <= 7'd0;
                state <= radio_ph_pkg::ST_RXBODY;
              end else if (i_rx.data == sync_at(sync_pat, sync_len, cnt)) begin
                cnt <= cnt + 16'h0001;
              end else begin
                cnt <= 16'(i_rx.data == sync_at(sync_pat, sync_len,
                    16'h0000));
              end
            end
          end
          radio_ph_pkg::ST_RXCRC: begin
            if (rx_v) begin
              lfsr <= lfsr8(lfsr);
              rcrc <= {rcrc[7:0], rx_raw};
              cnt <= cnt + 16'h0001;
              if (crc_fail) begin
                cnt <= 16'h0000;
                state <= radio_ph_pkg::ST_HUNT;
              end else if (rx_fin) begin
                state <= cipher_en ? radio_ph_pkg::ST_CIPHER
                    : radio_ph_pkg::ST_DONE;
              end
            end
          end
          radio_ph_pkg::ST_DONE: state <= radio_ph_pkg::ST_DONE;
          default: state <= radio_ph_pkg::ST_IDLE;
        endcase
      end
    end
  end

  wire set_ready = (rx_fin && !cipher_en)
      || (c_done && c_last && dec);
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      f_sent <= 1'b0;
      f_pass <= 1'b0;
      f_ready <= 1'b0;
      f_sync <= 1'b0;
    end else begin
      f_sent <= tx_done || (f_sent && !(st_clr && i_wb_dat[6]));
      f_pass <= (rxc_end && crc_ok)
          || (f_pass && !(st_clr && i_wb_dat[5]));
      f_ready <= set_ready || (f_ready && !(st_clr && i_wb_dat[4]));
      f_sync <= sync_hit || (f_sync && !(st_clr && i_wb_dat[3]));
    end
  end

  wire radio_ph_pkg::status_t status = '{busy: !s_idle, frame_sent: f_sent,
      checksum_pass: f_pass, frame_ready: f_ready, sync_match: f_sync,
      level: level, has_data: has_data, full: full};
  logic [31:0] rd_mux;
  always_comb begin
    case (i_wb_adr)
      `OFS_FIFO: rd_mux = has_data ? {24'h00_0000, body_raw} : 32'h0000_0000;
      `OFS_MODE: rd_mux = {30'h0000_0000, mode};
      `OFS_PKTCFG: rd_mux = pktcfg;
      `OFS_IDS: rd_mux = ids;
      `OFS_FRAMING: rd_mux = framing;
      `OFS_SYNC: rd_mux = sync_pat;
      `OFS_STATUS: rd_mux = {24'h00_0000, status};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      mode <= 2'b00;
      pktcfg <= `RST_PKTCFG;
      ids <= `RST_IDS;
      framing <= `RST_FRAMING;
      sync_pat <= `RST_SYNC;
      key <= 128'h0;
    end else begin
      ack <= acc && !ack;
      if (acc && !ack) rdata <= rd_mux;
      if (wr_en) begin
        case (i_wb_adr)
          `OFS_MODE: mode <= 2'(merge(32'(mode), i_wb_dat, i_wb_sel));
          `OFS_PKTCFG: pktcfg <= merge(pktcfg, i_wb_dat, i_wb_sel);
          `OFS_IDS: ids <= merge(ids, i_wb_dat, i_wb_sel);
          `OFS_FRAMING: framing <= merge(framing, i_wb_dat, i_wb_sel);
          `OFS_SYNC: sync_pat <= merge(sync_pat, i_wb_dat, i_wb_sel);
          default: begin
            if (key_hit) begin
              key[32 * i_wb_adr[3:2] +: 32] <= merge(
                  key[32 * i_wb_adr[3:2] +: 32], i_wb_dat, i_wb_sel);
            end
          end
        endcase
      end
    end
  end

  assign o_wb_ack = ack;
  assign o_wb_dat = rdata;
  assign o_tx = tx_q;
  assign o_manchester_on = bal == 2'b01;
  assign o_event_pin_zero = run_mode == 2'(radio_ph_pkg::MODE_RX)
      ? f_ready : f_sent;
endmodule
`default_nettype wire

// >>> tb/radio_ph_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module radio_ph_monitor (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire radio_ph_pkg::sym_t o_tx,
  input wire logic i_tx_ready,
  input wire logic o_manchester_on
);
  logic [1:0] bal;
  logic wr_d;
  wire req = i_wb_cyc && i_wb_stb;
  wire rd_ack = o_wb_ack && req && !i_wb_we;
  wire cfg_wr = o_wb_ack && req && i_wb_we && i_wb_adr == 8'h08
    && i_wb_sel[0];
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      bal <= 2'b00;
      wr_d <= 1'b0;
    end else begin
      wr_d <= cfg_wr;
      if (cfg_wr) begin
        bal <= i_wb_dat[2:1];
      end
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_prompt_a: assert property (req && !o_wb_ack |=> o_wb_ack)
    else $error("ack not one cycle after request");
  ack_no_req_a: assert property (!req |=> !o_wb_ack)
    else $error("ack without request");
  tx_hold_a: assert property (o_tx.valid && !i_tx_ready
    |=> o_tx.valid && $stable(o_tx.data))
    else $error("tx byte changed before taken");
  key_hidden_a: assert property (
    rd_ack && i_wb_adr[7:4] == 4'h2 |-> o_wb_dat == 32'h0000_0000)
    else $error("key word readable");
  reset_quiet_a: assert property (disable iff (1'b0)
    !i_reset_n |=> !o_tx.valid && !o_wb_ack)
    else $error("outputs active after reset");
  manchester_sel_a: assert property (
    !wr_d |-> o_manchester_on == (bal == 2'b01))
    else $error("manchester enable wrong");
  ready_after_sync_a: assert property (
    rd_ack && i_wb_adr == 8'h18 && o_wb_dat[4] |-> o_wb_dat[3])
    else $error("frame ready without sync flag");
endmodule
bind radio_packet_handler radio_ph_monitor i_mon (.i_core_clk,
  .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
  .i_wb_sel, .o_wb_dat, .o_wb_ack, .o_tx, .i_tx_ready,
  .o_manchester_on);
`default_nettype wire

// >>> tb/radio_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module radio_modem_model (
  input wire logic i_core_clk,
  input wire radio_ph_pkg::sym_t i_tx,
  output logic o_tx_ready,
  output radio_ph_pkg::sym_t o_rx
);
  logic [1:0] pace = 2'h0;
  logic [7:0] got[$];
  assign o_tx_ready = pace != 2'h2;
  initial o_rx = '0;
  // Stalls one cycle in four and records every byte taken
  always @(posedge i_core_clk) begin
    pace <= pace + 2'h1;
    if (i_tx.valid && o_tx_ready) begin
      got.push_back(i_tx.data);
    end
  end
  // Idle data is inverted so a stale byte never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge i_core_clk);
    o_rx <= '{1'b1, b};
    @(posedge i_core_clk);
    o_rx <= '{1'b0, ~b};
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic ack, tx_ready, man_on, ev;
  radio_ph_pkg::sym_t tx, rx;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] fr[3];
  logic [7:0] sb[$];
  logic [15:0] c;
  always #10 clk = ~clk;
  radio_packet_handler #(.BLOCK_CYC(4)) i_radio_packet_handler (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_tx(tx), .i_tx_ready(tx_ready),
    .i_rx(rx), .o_manchester_on(man_on), .o_event_pin_zero(ev));
  radio_modem_model modem (.i_core_clk(clk), .i_tx(tx),
    .o_tx_ready(tx_ready), .o_rx(rx));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) n_mismatch++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      rd(8'h18);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (q[b] !== 1'b1) n_mismatch++;
  endtask
  task automatic tail(input logic [7:0] e[$]);
    int o;
    repeat (4) @(posedge clk);
    o = modem.got.size() - e.size();
    for (int i = 0; i < e.size(); i++)
      chk("tx byte", 32'(modem.got[o + i]), 32'(e[i]));
  endtask
  function automatic logic [15:0] crc(input logic [7:0] b[3]);
    logic [15:0] r;
    r = 16'hFFFF;
    for (int i = 0; i < 3; i++) begin
      r = r ^ {b[i], 8'h00};
      for (int k = 0; k < 8; k++)
        r = r[15] ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
    end
    return r;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h08);
    chk("pktcfg reset", q, 32'h0000_0008);
    rd(8'h0C);
    chk("ids reset", q, 32'h0000_0F40);
    wr(8'h20, 32'h1234_5678);
    rd(8'h20);
    chk("key hidden", q, 32'h0000_0000);
    rd(8'h40);
    chk("unmapped", q, 32'h0000_0000);
    fr = '{8'h11, 8'h22, 8'h33};
    wr(8'h10, 32'h0002_0002);
    wr(8'h14, 32'h2DD4_5AA5);
    wr(8'h0C, 32'h0000_0203);
    for (int i = 0; i < 3; i++) wr(8'h00, {24'h00_0000, fr[i]});
    wr(8'h04, 32'h0000_0001);
    wait_flag(6);
    c = crc(fr);
    tail({8'hAA, 8'hAA, 8'h5A, 8'hA5, fr[0], fr[1], fr[2], c[15:8],
      c[7:0]});
    chk("frame size", modem.got.size(), 9);
    wr(8'h04, 32'h0000_0000);
    wr(8'h18, 32'h0000_00FF);
    modem.got.delete();
    wr(8'h10, 32'h0002_0000);
    wr(8'h0C, 32'h0000_0102);
    wr(8'h08, 32'h0000_0002);
    wr(8'h04, 32'h0000_0001);
    repeat (20) @(posedge clk);
    wr(8'h00, 32'h0000_0033);
    repeat (20) @(posedge clk);
    chk("fill seen", 32'(modem.got.size() > 0), 1);
    foreach (modem.got[i]) chk("fill", 32'(modem.got[i]), 0);
    wr(8'h00, 32'h0000_0044);
    wait_flag(6);
    tail({8'h5A, 8'hA5, 8'h33, 8'h44});
    wr(8'h04, 32'h0000_0000);
    wr(8'h18, 32'h0000_00FF);
    wr(8'h0C, 32'h0000_05FF);
    wr(8'h08, 32'h0000_0101);
    wr(8'h04, 32'h0000_0001);
    repeat (10) @(posedge clk);
    wr(8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0055);
    wait_flag(6);
    tail({8'h5A, 8'hA5, 8'h01, 8'h55});
    wr(8'h08, 32'h0000_0028);
    wr(8'h0C, 32'h0042_0003);
    for (int t = 0; t < 3; t++) begin
      fr = '{t == 1 ? 8'h77 : 8'h42, 8'h11, 8'h22};
      c = crc(fr) ^ (t == 2 ? 16'h0001 : 16'h0000);
      wr(8'h04, 32'h0000_0000);
      wr(8'h18, 32'h0000_00FF);
      wr(8'h04, 32'h0000_0002);
      sb = {8'hAA, 8'h5A, 8'hA5, fr[0], fr[1], fr[2], c[15:8], c[7:0]};
      foreach (sb[i]) modem.send(sb[i]);
      repeat (8) @(posedge clk);
      rd(8'h18);
      chk("frame ready", 32'(q[4]), 32'(t == 0));
      chk("event pin", 32'(ev), 32'(t == 0));
      chk("fifo data", 32'(q[1]), 32'(t == 0));
      if (t == 0) begin
        chk("sync flag", 32'(q[3]), 1);
        chk("crc pass", 32'(q[5]), 1);
        for (int i = 0; i < 3; i++) begin
          rd(8'h00);
          chk("rx byte", q, 32'(fr[i]));
        end
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
